// ---- hdl/rvf_fetch.sv ----
// reset-exit vector fetch: strap capture, vector read, pc load
`timescale 1ns/1ps
// Contract
// - read vector word, jump to it
// - straps sampled while reset held
// - straps map to four addresses/buses
// - boot mode supplies loader address internally
// - narrow variant drives low 24 bits
// - narrow variant asserts local strobes
module rvf_fetch import rvf_pkg::*; #(
   parameter bit NARROW = 1'b0,
   parameter int STRB_W = 2,
   parameter logic [31:0] BOOT_LOADER_ADDR = 32'h0000_1000
) (
   // clock and internal reset
   input wire logic ref_clk,
   input wire logic srst,
   // device pins: reset and straps (asynchronous)
   input wire logic reset_n_pin,
   input wire logic [1:0] vector_select_straps,
   input wire logic onchip_rom_boot_strap,
   // vector read port toward the external bus interface
   output logic vec_rd_req,
   output logic vec_rd_global,
   output logic [31:0] vec_rd_addr,
   input wire logic vec_rd_done,
   input wire logic [31:0] vec_rd_data,
   // narrow variant address pins and strobes
   output logic [RVF_NARROW_BITS-1:0] global_addr_pins,
   output logic [RVF_NARROW_BITS-1:0] local_addr_pins,
   output logic [STRB_W-1:0] local_bus_strobes_n,
   // core side
   output logic [31:0] pc_out,
   output logic fetch_enable
);
   // synchronised pin levels
   logic [3:0] pins_sync;
   wire reset_n_s = pins_sync[3];
   wire [1:0] straps_s = pins_sync[2:1];
   wire boot_s = pins_sync[0];

   rvf_sync #(.WIDTH(4)) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .din({reset_n_pin, vector_select_straps, onchip_rom_boot_strap}),
      .dout(pins_sync)
   );

   // state and captured values
   rvf_state_t state_reg, state_next;
   logic [1:0] straps_reg;
   logic boot_reg;
   logic [31:0] pc_reg;
   logic [31:0] addr_reg;
   logic global_reg;
   logic [3:0] low_cnt_reg;

   function automatic logic [31:0] vec_addr(input logic [1:0] s);
      unique case (s)
         2'b00: vec_addr = RVF_VEC_LOC00;
         2'b01: vec_addr = RVF_VEC_LOC01;
         2'b10: vec_addr = RVF_VEC_LOC10;
         2'b11: vec_addr = RVF_VEC_LOC11;
      endcase
   endfunction

   // high strap selects the global bus
   wire sel_global = straps_reg[1];
   wire [31:0] sel_addr = vec_addr(straps_reg);
   // pin low means reset is applied
   wire in_reset = !reset_n_s;
   // count reset cycles, saturating at minimum
   wire reset_ok = (low_cnt_reg == RVF_RESET_MIN);

   // next state of the fetch sequence
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         // wait for release after valid reset
         RVF_IDLE: begin
            if (!in_reset && reset_ok) begin
               // boot mode skips the external read
               state_next = boot_reg ? RVF_RUN : RVF_REQ;
            end
         end
         // issue request
         RVF_REQ: begin
            state_next = RVF_WAIT;
         end
         RVF_WAIT: begin
            if (vec_rd_done) begin
               state_next = RVF_RUN;
            end
         end
         // executing
         RVF_RUN: begin
            state_next = RVF_RUN;
         end
      endcase
      // any new reset restarts the sequence
      if (in_reset) begin
         state_next = RVF_IDLE;
      end
   end

   // state and reset count registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= RVF_IDLE;
         low_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (in_reset && !reset_ok) begin
            low_cnt_reg <= low_cnt_reg + 4'h1;
         end else if (state_reg == RVF_RUN) begin
            low_cnt_reg <= 4'h0;
         end
      end
   end

   // straps follow the pins while reset held
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         straps_reg <= 2'b00;
         boot_reg <= 1'b0;
      end else if (in_reset) begin
         straps_reg <= straps_s;
         boot_reg <= boot_s;
      end
   end

   // request address and bus, latched on entering request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         addr_reg <= 32'h0000_0000;
         global_reg <= 1'b0;
      end else if (state_reg == RVF_IDLE) begin
         addr_reg <= sel_addr;
         global_reg <= sel_global;
      end
   end

   // load pc from the vector word
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pc_reg <= RVF_PC_RESET;
      end else if (state_reg == RVF_WAIT && vec_rd_done) begin
         pc_reg <= vec_rd_data;
      end else if (state_reg == RVF_IDLE && !in_reset && reset_ok
                   && boot_reg) begin
         pc_reg <= BOOT_LOADER_ADDR;
      end
   end

   // request port
   wire req_active = (state_reg == RVF_REQ) || (state_reg == RVF_WAIT);
   assign vec_rd_req = req_active;
   assign vec_rd_global = global_reg;
   assign vec_rd_addr = addr_reg;
   // only low bits driven in narrow variant
   assign global_addr_pins = NARROW ? addr_reg[RVF_NARROW_BITS-1:0]
                                    : '0;
   assign local_addr_pins = NARROW ? addr_reg[RVF_NARROW_BITS-1:0]
                                   : '0;
   // local strobes active low during narrow fetch
   assign local_bus_strobes_n = (NARROW && req_active)
                                ? '0 : '1;
   assign fetch_enable = (state_reg == RVF_RUN);
   assign pc_out = pc_reg;

   // pc equals vector data after read
   chk_pc_load: assert property (@(posedge ref_clk)
      disable iff (srst)
      (state_reg == RVF_WAIT && vec_rd_done && !in_reset)
      |=> (pc_out == $past(vec_rd_data) && fetch_enable))
      else $error("pc not loaded from vector");
   chk_addr_map: assert property (@(posedge ref_clk)
      disable iff (srst)
      $rose(vec_rd_req) |-> (vec_rd_addr == vec_addr(straps_reg)
      && vec_rd_global == straps_reg[1]))
      else $error("vector address mismatch");
   chk_no_fetch: assert property (@(posedge ref_clk)
      disable iff (srst)
      vec_rd_req |-> !fetch_enable)
      else $error("fetch during vector read");
   chk_boot_skip: assert property (@(posedge ref_clk)
      disable iff (srst)
      (state_reg == RVF_IDLE && boot_reg && reset_ok && !in_reset)
      |=> (fetch_enable && pc_out == BOOT_LOADER_ADDR && !vec_rd_req))
      else $error("boot vector not internal");
   // strobes track the request in narrow variant
   chk_strobes: assert property (@(posedge ref_clk)
      disable iff (srst)
      NARROW |-> ((local_bus_strobes_n == '0) == vec_rd_req))
      else $error("strobes do not track request");
   // release before ten cycles is ignored
   chk_reset_len: assert property (@(posedge ref_clk)
      disable iff (srst)
      (state_reg == RVF_IDLE && !reset_ok) |=> !vec_rd_req)
      else $error("fetch after short reset");
   chk_reset_idle: assert property (@(posedge ref_clk)
      disable iff (srst)
      in_reset |=> (!fetch_enable && !vec_rd_req))
      else $error("activity during reset");
   chk_narrow_addr: assert property (@(posedge ref_clk)
      disable iff (srst)
      (NARROW && vec_rd_req) |-> ##1 (!vec_rd_req ||
      local_addr_pins == vec_rd_addr[RVF_NARROW_BITS-1:0]))
      else $error("narrow address wrong");
   // captured straps frozen once reset released
   chk_strap_hold: assert property (@(posedge ref_clk)
      disable iff (srst)
      !in_reset |=> $stable(straps_reg))
      else $error("straps changed outside reset");
   // execution stays on until the next reset
   chk_run_hold: assert property (@(posedge ref_clk)
      disable iff (srst)
      (fetch_enable && !in_reset) |=> fetch_enable)
      else $error("fetch enable dropped while running");
endmodule

// ---- hdl/rvf_pkg.sv ----
// package for the reset vector fetch block
package rvf_pkg;
   // vector addresses chosen by the select straps
   localparam logic [31:0] RVF_VEC_LOC00 = 32'h0000_0000;
   localparam logic [31:0] RVF_VEC_LOC01 = 32'h7fff_ffff;
   localparam logic [31:0] RVF_VEC_LOC10 = 32'h8000_0000;
   localparam logic [31:0] RVF_VEC_LOC11 = 32'hffff_ffff;
   // narrow variant drives this many address bits
   localparam int RVF_NARROW_BITS = 24;
   // value after reset of the program counter
   localparam logic [31:0] RVF_PC_RESET = 32'h0000_0000;
   // cycles of reset seen before straps count as captured
   localparam logic [3:0] RVF_RESET_MIN = 4'ha;
   // fetch sequence states
   typedef enum logic [1:0] {
      RVF_IDLE, RVF_REQ, RVF_WAIT, RVF_RUN
   } rvf_state_t;
endpackage

// ---- hdl/rvf_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rvf_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // asynchronous input and its synchronised copy
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // first stage, read only by the second stage
   logic [WIDTH-1:0] meta_reg;
   // both stages clear on reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_reg <= '0;
         dout <= '0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule

// ---- test/rvf_mem_model.sv ----
// external memory model answering the vector read
`timescale 1ns/1ps
module rvf_mem_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // read port and chosen answer delay
   input wire logic vec_rd_req,
   input wire logic [31:0] vec_rd_addr,
   input wire logic [3:0] lat,
   output logic vec_rd_done,
   output logic [31:0] vec_rd_data
);
   logic [3:0] cnt_reg; // cycles since request
   logic sent_reg; // one answer per request
   logic [31:0] junk_reg; // changing idle pattern
   assign vec_rd_data = vec_rd_done ? ~vec_rd_addr : junk_reg;
   // answer after lat cycles, once
   always_ff @(posedge ref_clk) begin
      vec_rd_done <= 1'b0;
      if (srst) begin
         // idle pattern restarts from a known seed
         junk_reg <= 32'h5a5a_a5a5;
         cnt_reg <= 4'h0;
         sent_reg <= 1'b0;
      end else begin
         junk_reg <= ~junk_reg ^ {31'h0, cnt_reg[0]};
         if (!vec_rd_req) begin
            cnt_reg <= 4'h0;
            sent_reg <= 1'b0;
         end else if (!sent_reg && cnt_reg == lat) begin
            vec_rd_done <= 1'b1;
            sent_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule

// ---- test/testbench.sv ----
// testbench for the reset vector fetch block
`timescale 1ns/1ps
module testbench;
   import rvf_pkg::*;
   logic ref_clk = 1'b0, srst = 1'b1, rst_n = 1'b0, boot = 1'b0;
   logic [1:0] straps = 2'h0;
   logic [3:0] lat = 4'h1;
   logic req, glb, done, fen, seen, strb_ok, en_ok;
   logic [31:0] addr, data, pc;
   logic [23:0] gpins, lpins, pin_cap;
   logic [1:0] strb_n;
   int miscompares = 0, samples_checked = 0;
   logic [31:0] locs [4] = '{RVF_VEC_LOC00, RVF_VEC_LOC01,
      RVF_VEC_LOC10, RVF_VEC_LOC11};
   rvf_fetch #(.NARROW(1'b1)) i_rvf_fetch (.ref_clk(ref_clk),
      .srst(srst), .reset_n_pin(rst_n), .vector_select_straps(straps),
      .onchip_rom_boot_strap(boot), .vec_rd_req(req),
      .vec_rd_global(glb), .vec_rd_addr(addr), .vec_rd_done(done),
      .vec_rd_data(data), .global_addr_pins(gpins),
      .local_addr_pins(lpins), .local_bus_strobes_n(strb_n),
      .pc_out(pc), .fetch_enable(fen));
   rvf_mem_model i_rvf_mem_model (.ref_clk(ref_clk), .srst(srst),
      .vec_rd_req(req), .vec_rd_addr(addr), .lat(lat),
      .vec_rd_done(done), .vec_rd_data(data));
   // 200 MHz clock
   initial forever #2.5 ref_clk = ~ref_clk;
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // pin held low, then released; watch the fetch
   task run_exit(input logic [1:0] s, input logic b, input int low,
                 input logic [3:0] l);
      @(posedge ref_clk);
      {seen, strb_ok, en_ok} = 3'b011;
      lat <= l;
      straps <= s;
      boot <= b;
      rst_n <= 1'b0;
      repeat (low) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int n = 0; n < 40 && fen !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
         if (req === 1'b1) begin
            seen = 1'b1;
            pin_cap = gpins;
            if (strb_n !== 2'b00 || lpins !== gpins) strb_ok = 1'b0;
            if (fen !== 1'b0) en_ok = 1'b0;
         end
      end
   endtask
   // every strap code, prompt and slow memory
   task sc_vectors;
      for (int i = 0; i < 4; i++) begin
         run_exit(i[1:0], 1'b0, 12, i[0] ? 4'h6 : 4'h1);
         chk({31'h0, seen}, 32'h1);
         chk(addr, locs[i]);
         chk({31'h0, glb}, {31'h0, i[1]});
         chk(pc, ~locs[i]);
         chk({31'h0, fen}, 32'h1);
         chk({8'h0, pin_cap}, {8'h0, locs[i][23:0]});
         chk({31'h0, strb_ok}, 32'h1);
         chk({30'h0, strb_n}, 32'h3);
         chk({31'h0, en_ok}, 32'h1);
      end
   endtask
   // boot mode: loader address, no external read
   task sc_boot;
      run_exit(2'b00, 1'b1, 12, 4'h1);
      chk({31'h0, fen}, 32'h1);
      chk(pc, 32'h0000_1000);
      chk({31'h0, seen}, 32'h0);
   endtask
   // too short a pulse after a fresh reset starts nothing
   task sc_short;
      @(posedge ref_clk);
      srst <= 1'b1;
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      run_exit(2'b01, 1'b0, 4, 4'h1);
      chk({31'h0, fen}, 32'h0);
      chk({31'h0, seen}, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      sc_vectors;
      sc_boot;
      sc_short;
      report_and_stop;
   end
   // hang guard
   initial begin
      #5000;
      miscompares++;
      report_and_stop;
   end
endmodule
